/* fps_flash_model.sv */
`timescale 1ns/100ps
`default_nettype none
module fps_flash_model
  import fps_pkg::*;
(
  input  wire logic              clk,      // clock
  input  wire logic              fl_start, // op pulse
  input  wire logic [2:0]        fl_op,    // operation
  input  wire logic              fl_ee,    // data area
  input  wire logic [ADDR_W-1:0] fl_addr,  // address
  input  wire logic [7:0]        fl_wdata, // program data
  input  wire logic              slow,     // stretch busy
  output logic                   fl_busy,  // busy
  output logic      [7:0]        fl_rdata  // read data
);
  logic [7:0] mem [logic [15:0]];
  logic [7:0] res;
  int         cnt;

  initial begin
    fl_busy  = 1'b0;
    fl_rdata = 8'h00;
    cnt      = 0;
  end

  // ==========================================================
  // array and busy timing; read data toggles while busy
  always @(posedge clk) begin
    if (fl_start) begin
      res = mem.exists({fl_ee, fl_addr}) ? mem[{fl_ee, fl_addr}] : 8'hFF;
      if (fl_op == F_PROG)
        mem[{fl_ee, fl_addr}] = fl_wdata;
      if (fl_op == F_SERA)
        for (int i = 0; i < 512; i++)
          mem.delete({fl_ee, fl_addr[14:9], 9'(i)});
      if (fl_op == F_MASS || fl_op == F_EERA)
        for (int i = 0; i < 32768; i++)
          mem.delete({fl_op == F_EERA, 15'(i)});
      cnt = slow ? 5 : 0;
      fl_busy  <= slow;
      fl_rdata <= slow ? ~res : res;
    end else if (cnt > 0) begin
      cnt = cnt - 1;
      fl_busy  <= cnt > 0;
      fl_rdata <= cnt > 0 ? ~fl_rdata : res;
    end
  end
endmodule : fps_flash_model
`default_nettype wire

/* fps_monitor.sv */
`timescale 1ns/100ps
`default_nettype none
module fps_monitor
  import fps_pkg::*;
(
  input wire logic              clk,             // clock
  input wire logic              sys_rst,         // reset
  input wire logic [SEC_W-1:0]  cpu_exec_sector, // running sector
  input wire logic [ADDR_W-1:0] cpu_movc_addr,   // table read addr
  input wire logic              movc_block,      // table read refused
  input wire logic              icp_active,      // programming mode
  input wire logic              icp_valid,       // request
  input wire logic              icp_ready,       // idle
  input wire logic [3:0]        icp_cmd,         // command
  input wire logic              icp_done,        // finished
  input wire logic              icp_refused,     // refused
  input wire logic [7:0]        icp_rdata,       // read result
  input wire logic              fl_start,        // op pulse
  input wire logic [2:0]        fl_op,           // operation
  input wire logic              single_wire_program_pin, // entry pin
  input wire logic              jtag_tck,        // four-wire clock
  input wire logic              jtag_tms         // four-wire mode
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  // ==========================================================
  // sequences and properties
  sequence s_mass_take;
    icp_active && icp_valid && icp_ready && icp_cmd == C_MASS;
  endsequence
  property p_refuse_fill; icp_refused |-> icp_done && icp_rdata == READ_FILL; endproperty
  a_refuse_fill: assert property (p_refuse_fill) else $error("refused without fill");
  property p_refuse_nostart; icp_refused |-> !$past(fl_start, 3) && !fl_start; endproperty
  a_refuse_nostart: assert property (p_refuse_nostart) else $error("refused op pulsed");
  property p_mass_icp; fl_start && fl_op == F_MASS |-> icp_active; endproperty
  a_mass_icp: assert property (p_mass_icp) else $error("mass erase outside icp");
  property p_mass_go; s_mass_take |=> fl_start && fl_op == F_MASS; endproperty
  a_mass_go: assert property (p_mass_go) else $error("mass erase not started");
  property p_own_sector; cpu_movc_addr[14:9] == cpu_exec_sector |-> !movc_block; endproperty
  a_own_sector: assert property (p_own_sector) else $error("own sector blocked");
  property p_entry_rst; $past(sys_rst) |-> !icp_active; endproperty
  a_entry_rst: assert property (p_entry_rst) else $error("entry without waveform");
  property p_entry_wave;
    $rose(icp_active) |-> $past(single_wire_program_pin) || $past(jtag_tck && jtag_tms);
  endproperty
  a_entry_wave: assert property (p_entry_wave) else $error("entry without pin edge");
  property p_start_pulse; fl_start |=> !fl_start; endproperty
  a_start_pulse: assert property (p_start_pulse) else $error("start pulse too long");
  property p_done_bound; fl_start && icp_active |-> ##[3:40] icp_done; endproperty
  a_done_bound: assert property (p_done_bound) else $error("command not finished");
endmodule : fps_monitor

bind fps_top fps_monitor u_mon (
  .clk, .sys_rst, .cpu_exec_sector, .cpu_movc_addr, .movc_block, .icp_active, .icp_valid,
  .icp_ready, .icp_cmd, .icp_done, .icp_refused, .icp_rdata, .fl_start, .fl_op,
  .single_wire_program_pin, .jtag_tck, .jtag_tms
);
`default_nettype wire

/* fps_pkg.sv */
package fps_pkg;

  // ==========================================================
  // geometry
  localparam int SEC_W  = 6;
  localparam int NSEC   = 64;
  localparam int OFS_W  = 9;
  localparam int ADDR_W = 15;
  localparam int PW_N   = 6;

  // ==========================================================
  // register offsets
  localparam logic [7:0] A_OPTYPE = 8'hF2;
  localparam logic [7:0] A_KEY1   = 8'hF3;
  localparam logic [7:0] A_KEY2   = 8'hF4;
  localparam logic [7:0] A_KEY3   = 8'hF5;
  localparam logic [7:0] A_KEY4   = 8'hF6;
  localparam logic [7:0] A_PAGE   = 8'hF7;
  localparam logic [7:0] A_GO     = 8'hF8;
  localparam logic [7:0] A_STAT   = 8'hF9;
  localparam logic [7:0] A_OFFSET = 8'hFB;
  localparam logic [7:0] A_DATA   = 8'hFC;

  // ==========================================================
  // register values and fields
  localparam logic [7:0] OP_ERASE  = 8'hE6;
  localparam logic [7:0] OP_PROG   = 8'h6E;
  localparam logic [3:0] KEY1_VAL  = 4'h5;
  localparam logic [3:0] KEY2_VAL  = 4'hA;
  localparam logic [3:0] KEY3_VAL  = 4'h9;
  localparam logic [3:0] KEY4_VAL  = 4'h6;
  localparam logic [7:0] RST8      = 8'h00;
  localparam logic [6:0] RST7      = 7'h00;
  localparam logic [3:0] RST4      = 4'h0;
  localparam logic [7:0] READ_FILL = 8'hFF;
  localparam int GO_START = 0;
  localparam int GO_READ  = 1;
  localparam int GO_EE    = 2;

  // ==========================================================
  // programmer commands
  localparam logic [3:0] C_READ  = 4'h1;
  localparam logic [3:0] C_WRITE = 4'h2;
  localparam logic [3:0] C_SERA  = 4'h3;
  localparam logic [3:0] C_MASS  = 4'h4;
  localparam logic [3:0] C_EERA  = 4'h5;
  localparam logic [3:0] C_EERD  = 4'h6;
  localparam logic [3:0] C_EEWR  = 4'h7;
  localparam logic [3:0] C_PROT  = 4'h8;
  localparam logic [3:0] C_SETPW = 4'h9;
  localparam logic [3:0] C_PW    = 4'hA;
  localparam logic [3:0] C_EXIT  = 4'hB;

  // flash macro operations
  localparam logic [2:0] F_NONE = 3'h0;
  localparam logic [2:0] F_RD   = 3'h1;
  localparam logic [2:0] F_PROG = 3'h2;
  localparam logic [2:0] F_SERA = 3'h3;
  localparam logic [2:0] F_MASS = 3'h4;
  localparam logic [2:0] F_EERA = 3'h5;

  // ==========================================================
  // entry detection timing
  localparam int CLK_NS     = 8;
  localparam int SW_GAP_NS  = 2000;
  localparam int SW_GAP_CYC = SW_GAP_NS / CLK_NS;
  localparam logic [4:0] SW_EDGES = 5'h10;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'h1,
    ST_PULSE = 4'h2,
    ST_WAIT  = 4'h4,
    ST_DONE  = 4'h8
  } fps_state_t;

  function automatic logic [SEC_W-1:0] fps_sec(input logic [ADDR_W-1:0] a);
    fps_sec = a[ADDR_W-1:OFS_W];
  endfunction : fps_sec

endpackage : fps_pkg

/* fps_tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin n_mismatch++; $display("Error %s expected %h seen %h", nm, e, g); end end
module fps_tb_top;
  import fps_pkg::*;
  localparam logic [15:0] JKEY = 16'h3C5A; // arbitrary entry key
  localparam logic [15:0] KOK  = 16'h5A96;
  logic              clk, sys_rst, reg_wr, reg_rd, movc_block, single_wire_program_pin, rf;
  logic              jtag_tck, jtag_tdi, jtag_tms, jtag_tdo, icp_active, icp_valid, icp_ready;
  logic              icp_done, icp_refused, fl_start, fl_ee, fl_busy, slow;
  logic [7:0]        reg_addr, reg_wdata, reg_rdata, icp_wdata, icp_rdata, fl_wdata, fl_rdata;
  logic [7:0]        q, st, d3, de, d9;
  logic [7:0]        pw [PW_N];
  logic [SEC_W-1:0]  cpu_exec_sector;
  logic [ADDR_W-1:0] cpu_movc_addr, icp_addr, fl_addr;
  logic [3:0]        icp_cmd;
  logic [2:0]        fl_op;
  logic [8:0]        o9;
  logic [31:0]       rnd;
  int                n_mismatch, checks;

  fps_top #(.JT_ENTRY_KEY(JKEY)) u_dut (
    .clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .cpu_exec_sector,
    .cpu_movc_addr, .movc_block, .single_wire_program_pin, .jtag_tck, .jtag_tdi, .jtag_tms,
    .jtag_tdo, .icp_active, .icp_valid, .icp_ready, .icp_cmd, .icp_addr, .icp_wdata,
    .icp_done, .icp_refused, .icp_rdata, .fl_start, .fl_op, .fl_ee, .fl_addr, .fl_wdata,
    .fl_busy, .fl_rdata
  );
  fps_flash_model u_flash (
    .clk, .fl_start, .fl_op, .fl_ee, .fl_addr, .fl_wdata, .slow, .fl_busy, .fl_rdata
  );

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  task automatic close_out();
    if (n_mismatch == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : close_out

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_rd    <= 1'b0;
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    reg_wr   <= 1'b0;
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
    d = reg_rdata;
  endtask : rd

  task automatic in_circuit_programming(input logic [3:0] c, input logic [14:0] a, input logic [7:0] d);
    int n;
    n = 0;
    icp_cmd   <= c;
    icp_addr  <= a;
    icp_wdata <= d;
    icp_valid <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (icp_ready !== 1'b1 && n < 60);
    icp_valid <= 1'b0;
    do begin
      @(posedge clk);
      n++;
    end while (icp_done !== 1'b1 && n < 120);
    if (icp_done !== 1'b1) begin
      n_mismatch++;
      close_out();
    end
    q  = icp_rdata;
    rf = icp_refused;
  endtask : in_circuit_programming

  // self op: optype, keys, sector, offset, data, go bits; leaves status in st, data reg in q
  task automatic self_sector_programming(input logic [7:0] op, input logic [15:0] k, input logic [5:0] s,
                     input logic [2:0] go, input logic [7:0] d);
    int n;
    n = 0;
    wr(A_OPTYPE, op);
    wr(A_KEY1, {4'h0, k[15:12]});
    wr(A_KEY2, {4'h0, k[11:8]});
    wr(A_KEY3, {4'h0, k[7:4]});
    wr(A_KEY4, {4'h0, k[3:0]});
    wr(A_PAGE, {1'b0, s, o9[8]});
    wr(A_OFFSET, o9[7:0]);
    wr(A_DATA, d);
    wr(A_GO, {5'h00, go});
    do begin
      rd(A_STAT, st);
      n++;
    end while (st[1:0] !== 2'b10 && n < 30);
    if (st[1:0] !== 2'b10) begin
      n_mismatch++;
      close_out();
    end
    rd(A_DATA, q);
  endtask : self_sector_programming

  task automatic sw_enter(input int e);
    repeat (e) begin
      single_wire_program_pin <= 1'b1;
      repeat (3) @(posedge clk);
      single_wire_program_pin <= 1'b0;
      repeat (3) @(posedge clk);
    end
    repeat (4) @(posedge clk);
  endtask : sw_enter

  initial begin
    {sys_rst, reg_wr, reg_rd, single_wire_program_pin, jtag_tck, jtag_tdi} <= 6'h21;
    {jtag_tms, icp_valid, slow, reg_addr, reg_wdata, icp_cmd, icp_wdata} <= 31'h0;
    {cpu_exec_sector, cpu_movc_addr, icp_addr} <= 36'h0;
    n_mismatch = 0;
    checks = 0;
    rnd = 32'h0000_83EC;
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    rd(A_PAGE, q);
    `CHK("page reset", 8'h00, q)
    wr(A_PAGE, 8'hFF);
    rd(A_PAGE, q);
    `CHK("page width", 8'h7F, q)
    rd(8'h80, q);
    `CHK("unmapped", 8'h00, q)
    sw_enter(15);
    `CHK("short entry", 1'b0, icp_active)
    repeat (300) @(posedge clk);
    sw_enter(16);
    `CHK("wire entry", 1'b1, icp_active)
    rnd = lfsr(rnd);
    {o9, de, d3} = rnd[24:0];
    in_circuit_programming(C_WRITE, {6'h03, o9}, d3);
    in_circuit_programming(C_READ, {6'h03, o9}, 8'h00);
    `CHK("icp read", d3, q)
    in_circuit_programming(C_EEWR, {6'h00, o9}, de);
    in_circuit_programming(C_PROT, 15'h0600, 8'h01);
    in_circuit_programming(C_PROT, 15'h0C00, 8'h04);
    in_circuit_programming(C_PROT, 15'h0E00, 8'h02);
    in_circuit_programming(C_READ, {6'h03, o9}, 8'h00);
    `CHK("mode0 fill", 8'hFF, q)
    `CHK("mode0 read", 1'b1, rf)
    in_circuit_programming(C_SERA, {6'h03, o9}, 8'h00);
    `CHK("mode0 erase", 1'b1, rf)
    for (int i = 0; i < PW_N; i++) begin
      rnd = lfsr(rnd);
      pw[i] = rnd[7:0];
      in_circuit_programming(C_SETPW, 15'(i), pw[i]);
    end
    in_circuit_programming(C_PROT, 15'h0000, 8'h08);
    in_circuit_programming(C_EXIT, 15'h0000, 8'h00);
    slow <= 1'b1;
    self_sector_programming(8'h00, KOK, 6'h03, 3'h3, 8'h00);
    `CHK("self read", d3, q)
    self_sector_programming(8'h6E, KOK, 6'h06, 3'h1, d3);
    `CHK("mode2 prog", 1'b1, st[2])
    self_sector_programming(8'hE6, KOK, 6'h07, 3'h1, 8'h00);
    `CHK("mode1 erase", 1'b1, st[2])
    cpu_movc_addr <= {6'h07, o9};
    @(posedge clk);
    `CHK("movc other", 1'b1, movc_block)
    cpu_exec_sector <= 6'h07;
    @(posedge clk);
    `CHK("movc own", 1'b0, movc_block)
    self_sector_programming(8'h6E, KOK, 6'h07, 3'h1, d3);
    `CHK("own prog", 1'b0, st[2])
    cpu_exec_sector <= 6'h00;
    for (int i = 0; i < 5; i++) begin
      self_sector_programming(i == 4 ? 8'h66 : 8'h6E, KOK ^ (16'h0001 << (4 * i)), 6'h09, 3'h1, d3);
      `CHK("bad unlock", 1'b1, st[2])
    end
    rnd = lfsr(rnd);
    d9 = rnd[7:0];
    self_sector_programming(8'h6E, KOK, 6'h09, 3'h1, 8'h00);
    `CHK("self prog", 1'b0, st[2])
    self_sector_programming(8'h6E, KOK, 6'h09, 3'h1, d9);
    `CHK("reprogram", 1'b1, st[2])
    self_sector_programming(8'hE6, KOK, 6'h09, 3'h1, 8'h00);
    `CHK("self erase", 1'b0, st[2])
    self_sector_programming(8'h6E, KOK, 6'h09, 3'h1, d9);
    `CHK("after erase", 1'b0, st[2])
    slow <= 1'b0;
    jtag_tms <= 1'b1;
    for (int i = 15; i >= 0; i--) begin
      jtag_tdi <= JKEY[i];
      repeat (2) @(posedge clk);
      jtag_tck <= 1'b1;
      repeat (2) @(posedge clk);
      jtag_tck <= 1'b0;
    end
    jtag_tms <= 1'b0;
    repeat (4) @(posedge clk);
    `CHK("jtag entry", 1'b1, jtag_tdo)
    in_circuit_programming(C_READ, {6'h09, o9}, 8'h00);
    `CHK("no password", 1'b1, rf)
    for (int i = 0; i < PW_N; i++)
      in_circuit_programming(C_PW, 15'(i), pw[i]);
    in_circuit_programming(C_READ, {6'h09, o9}, 8'h00);
    `CHK("password read", d9, q)
    in_circuit_programming(C_SERA, {6'h09, o9}, 8'h00);
    in_circuit_programming(C_READ, {6'h09, o9}, 8'h00);
    `CHK("icp erase", 8'hFF, q)
    in_circuit_programming(C_MASS, 15'h0000, 8'h00);
    `CHK("mass", 1'b0, rf)
    in_circuit_programming(C_READ, {6'h03, o9}, 8'h00);
    `CHK("mass code", 8'hFF, q)
    in_circuit_programming(C_EERD, {6'h00, o9}, 8'h00);
    `CHK("mass data", de, q)
    in_circuit_programming(C_EXIT, 15'h0000, 8'h00);
    self_sector_programming(8'h6E, KOK, 6'h06, 3'h1, d3);
    `CHK("prot cleared", 1'b0, st[2])
    self_sector_programming(8'h00, KOK, 6'h00, 3'h7, 8'h00);
    `CHK("self data read", de, q)
    self_sector_programming(8'hE6, KOK, 6'h00, 3'h5, 8'h00);
    self_sector_programming(8'h00, KOK, 6'h00, 3'h7, 8'h00);
    `CHK("self data erase", 8'hFF, q)
    close_out();
  end
endmodule : fps_tb_top
`default_nettype wire

/* fps_top.sv */
// Decided for this implementation: the strobed register port.
`timescale 1ns/100ps
`default_nettype none

module fps_top
  import fps_pkg::*;
(
  input  wire logic              clk,             // system clock
  input  wire logic              sys_rst,         // sync reset
  input  wire logic [7:0]        reg_addr,        // register address
  input  wire logic [7:0]        reg_wdata,       // register write data
  input  wire logic              reg_wr,          // write strobe
  input  wire logic              reg_rd,          // read strobe
  output logic      [7:0]        reg_rdata,       // read data
  input  wire logic [SEC_W-1:0]  cpu_exec_sector, // sector of running code
  input  wire logic [ADDR_W-1:0] cpu_movc_addr,   // table read address
  output logic                   movc_block,      // table read blocked
  input  wire logic              single_wire_program_pin, // entry pin
  input  wire logic              jtag_tck,        // four-wire clock
  input  wire logic              jtag_tdi,        // four-wire data in
  input  wire logic              jtag_tms,        // four-wire mode
  output logic                   jtag_tdo,        // four-wire return
  output logic                   icp_active,      // programming mode
  input  wire logic              icp_valid,       // programmer command
  output logic                   icp_ready,       // command accepted
  input  wire logic [3:0]        icp_cmd,         // command code
  input  wire logic [ADDR_W-1:0] icp_addr,        // command address
  input  wire logic [7:0]        icp_wdata,       // command data
  output logic                   icp_done,        // command finished
  output logic                   icp_refused,     // command refused
  output logic      [7:0]        icp_rdata,       // read result
  output logic                   fl_start,        // flash op pulse
  output logic      [2:0]        fl_op,           // flash operation
  output logic                   fl_ee,           // data area target
  output logic      [ADDR_W-1:0] fl_addr,         // flash address
  output logic      [7:0]        fl_wdata,        // flash write data
  input  wire logic              fl_busy,         // flash busy
  input  wire logic [7:0]        fl_rdata         // flash read data
);

  parameter logic [15:0] JT_ENTRY_KEY = 16'hA53C;

  // ==========================================================
  // state
  fps_state_t             state;
  logic [NSEC-1:0]        prot_m0;
  logic [NSEC-1:0]        prot_m1;
  logic [NSEC-1:0]        prot_m2;
  logic [NSEC-1:0]        programmed;
  logic                   pw_en;
  logic [7:0]             pw_mem [PW_N];
  logic [2:0]             pw_idx;
  logic                   pw_match;
  logic                   pw_ok;
  logic [7:0]             optype;
  logic [3:0]             key1;
  logic [3:0]             key2;
  logic [3:0]             key3;
  logic [3:0]             key4;
  logic [6:0]             page;
  logic [7:0]             offset;
  logic [7:0]             data;
  logic                   st_done;
  logic                   st_err;
  logic                   cur_icp;
  logic                   cur_ee;
  logic [2:0]             cur_op;
  logic [ADDR_W-1:0]      cur_addr;
  logic                   sw_q;
  logic [4:0]             sw_cnt;
  logic [15:0]            sw_gap;
  logic                   tck_q;
  logic [15:0]            jt_shift;

  // ==========================================================
  // protection decode
  wire [SEC_W-1:0]  movc_sec  = fps_sec(cpu_movc_addr);
  wire [SEC_W-1:0]  icp_sec   = fps_sec(icp_addr);
  wire [SEC_W-1:0]  ssp_sec   = page[6:1];
  wire [ADDR_W-1:0] ssp_addr  = {ssp_sec, page[0], offset};
  wire [ADDR_W-1:0] ee_addr   = {3'h0, page[3:1], page[0], offset};
  wire              ssp_own   = ssp_sec == cpu_exec_sector;
  wire              pw_block  = pw_en & ~pw_ok;
  wire              icp_m0    = prot_m0[icp_sec];
  wire              ssp_m12   = prot_m1[ssp_sec] | prot_m2[ssp_sec];

  assign movc_block = prot_m1[movc_sec] &&
                      movc_sec != cpu_exec_sector;

  // ==========================================================
  // programmer request decode
  wire icp_take  = icp_active & icp_valid & icp_ready;
  wire icp_code  = icp_cmd == C_READ || icp_cmd == C_WRITE;
  wire icp_flash = icp_code || icp_cmd == C_SERA || icp_cmd == C_MASS ||
                   icp_cmd == C_EERA || icp_cmd == C_EERD ||
                   icp_cmd == C_EEWR;
  wire icp_ok    = icp_code ? ~icp_m0 & ~pw_block :
                   icp_cmd == C_SERA ? ~icp_m0 : 1'b1;
  wire [2:0] icp_fop = icp_cmd == C_READ || icp_cmd == C_EERD ? F_RD :
                       icp_cmd == C_SERA ? F_SERA :
                       icp_cmd == C_MASS ? F_MASS :
                       icp_cmd == C_EERA ? F_EERA : F_PROG;
  wire icp_is_ee = icp_cmd == C_EERA || icp_cmd == C_EERD ||
                   icp_cmd == C_EEWR;

  // ==========================================================
  // self-programming request decode
  wire go_wr    = reg_wr && reg_addr == A_GO && ~icp_active &&
                  state == ST_IDLE;
  wire go_start = go_wr & reg_wdata[GO_START];
  wire go_read  = reg_wdata[GO_READ];
  wire go_ee    = reg_wdata[GO_EE];
  wire keys_ok  = key1 == KEY1_VAL && key2 == KEY2_VAL &&
                  key3 == KEY3_VAL && key4 == KEY4_VAL;
  wire type_ok  = optype == OP_ERASE || optype == OP_PROG;
  wire ssp_era  = optype == OP_ERASE;
  wire code_ok  = ssp_own | ~ssp_m12;
  wire ssp_ok   = go_read ? (go_ee | code_ok) :
                  ~(keys_ok & type_ok) ? 1'b0 :
                  go_ee ? 1'b1 :
                  ssp_era ? (ssp_own | ~prot_m1[ssp_sec]) &
                            (ssp_own | ~prot_m2[ssp_sec]) :
                  code_ok & ~programmed[ssp_sec];
  wire [2:0] ssp_fop = go_read ? F_RD :
                       go_ee & ssp_era ? F_EERA :
                       ssp_era ? F_SERA : F_PROG;

  // launch only after every check passes; mass erase and own-sector self ops still reach protected sectors
  wire launch_icp = icp_take & icp_flash & icp_ok;
  wire launch_ssp = go_start & ssp_ok;
  wire pw_hit     = icp_wdata == pw_mem[pw_idx];

  // ==========================================================
  // entry detection: single wire edge train, four-wire serial key
  wire sw_rise   = single_wire_program_pin & ~sw_q;
  wire sw_enter  = sw_rise && sw_cnt == SW_EDGES - 5'h01;
  wire sw_tmo    = sw_gap == SW_GAP_CYC[15:0];
  wire tck_rise  = jtag_tck & ~tck_q;
  wire [15:0] jt_next = {jt_shift[14:0], jtag_tdi};
  wire jt_enter  = tck_rise & jtag_tms && jt_next == JT_ENTRY_KEY;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sw_q     <= 1'b0;
      sw_cnt   <= 5'h00;
      sw_gap   <= 16'h0000;
      tck_q    <= 1'b0;
      jt_shift <= 16'h0000;
    end else begin
      sw_q  <= single_wire_program_pin;
      tck_q <= jtag_tck;
      if (sw_rise) begin
        sw_gap <= 16'h0000;
        sw_cnt <= sw_enter ? 5'h00 : sw_cnt + 5'h01;
      end else if (sw_tmo) begin
        sw_cnt <= 5'h00;
      end else begin
        sw_gap <= sw_gap + 16'h0001;
      end
      if (tck_rise & jtag_tms) begin
        jt_shift <= jt_next;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      icp_active <= 1'b0;
    end else if (sw_enter | jt_enter) begin
      icp_active <= 1'b1;
    end else if (icp_take && icp_cmd == C_EXIT) begin
      icp_active <= 1'b0;
    end
  end

  assign jtag_tdo  = icp_active;
  assign icp_ready = state == ST_IDLE;

  // ==========================================================
  // protection store, written only by programmer commands
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pw_idx <= 3'h0;
      pw_ok  <= 1'b0;
    end else if (~icp_active) begin
      pw_idx <= 3'h0;
      pw_ok  <= 1'b0;
    end else if (icp_take && icp_cmd == C_PW) begin
      pw_idx   <= pw_idx == 3'(PW_N - 1) ? 3'h0 : pw_idx + 3'h1;
      pw_match <= pw_idx == 3'h0 ? pw_hit : pw_match & pw_hit;
      pw_ok    <= pw_idx == 3'(PW_N - 1) && pw_hit &&
                  (pw_match || PW_N == 1);
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      prot_m0 <= '0;
      prot_m1 <= '0;
      prot_m2 <= '0;
      pw_en   <= 1'b0;
    end else if (launch_icp && icp_cmd == C_MASS) begin
      prot_m0 <= '0;
      prot_m1 <= '0;
      prot_m2 <= '0;
      pw_en   <= 1'b0;
    end else if (icp_take && icp_cmd == C_PROT) begin
      prot_m0[icp_sec] <= icp_wdata[0];
      prot_m1[icp_sec] <= icp_wdata[1];
      prot_m2[icp_sec] <= icp_wdata[2];
      pw_en            <= pw_en | icp_wdata[3];
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      for (int i = 0; i < PW_N; i++) pw_mem[i] <= RST8;
    end else if (launch_icp && icp_cmd == C_MASS) begin
      for (int i = 0; i < PW_N; i++) pw_mem[i] <= RST8;
    end else if (icp_take && icp_cmd == C_SETPW && ~pw_block) begin
      pw_mem[icp_addr[2:0]] <= icp_wdata;
    end
  end

  // ==========================================================
  // register file
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      optype <= RST8;
      key1   <= RST4;
      key2   <= RST4;
      key3   <= RST4;
      key4   <= RST4;
      page   <= RST7;
      offset <= RST8;
    end else if (launch_ssp) begin
      key1 <= RST4;
      key2 <= RST4;
      key3 <= RST4;
      key4 <= RST4;
    end else if (reg_wr) begin
      case (reg_addr)
        A_OPTYPE: optype <= reg_wdata;
        A_KEY1:   key1   <= reg_wdata[3:0];
        A_KEY2:   key2   <= reg_wdata[3:0];
        A_KEY3:   key3   <= reg_wdata[3:0];
        A_KEY4:   key4   <= reg_wdata[3:0];
        A_PAGE:   page   <= reg_wdata[6:0];
        A_OFFSET: offset <= reg_wdata;
        default:  ;
      endcase
    end
  end

  wire [7:0] rd_mux =
    reg_addr == A_OPTYPE ? optype :
    reg_addr == A_KEY1   ? {4'h0, key1} :
    reg_addr == A_KEY2   ? {4'h0, key2} :
    reg_addr == A_KEY3   ? {4'h0, key3} :
    reg_addr == A_KEY4   ? {4'h0, key4} :
    reg_addr == A_PAGE   ? {1'b0, page} :
    reg_addr == A_OFFSET ? offset :
    reg_addr == A_DATA   ? data :
    reg_addr == A_STAT   ? {4'h0, icp_active, st_err, st_done,
                            state != ST_IDLE} : RST8;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      reg_rdata <= RST8;
    end else begin
      reg_rdata <= reg_rd ? rd_mux : RST8;
    end
  end

  // ==========================================================
  // sequencer
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state      <= ST_IDLE;
      cur_icp    <= 1'b0;
      cur_ee     <= 1'b0;
      cur_op     <= F_NONE;
      cur_addr   <= '0;
      fl_wdata   <= RST8;
      data       <= RST8;
      st_done    <= 1'b0;
      st_err     <= 1'b0;
      icp_done   <= 1'b0;
      icp_refused <= 1'b0;
      icp_rdata  <= RST8;
      programmed <= '0;
    end else begin
      icp_done    <= 1'b0;
      icp_refused <= 1'b0;
      if (reg_wr && reg_addr == A_DATA) data <= reg_wdata;
      case (state)
        ST_IDLE: begin
          if (launch_icp) begin
            state    <= ST_PULSE;
            cur_icp  <= 1'b1;
            cur_ee   <= icp_is_ee;
            cur_op   <= icp_fop;
            cur_addr <= icp_addr;
            fl_wdata <= icp_wdata;
          end else if (icp_take) begin
            icp_done    <= 1'b1;
            icp_refused <= icp_flash;
            icp_rdata   <= READ_FILL;
          end else if (launch_ssp) begin
            state    <= ST_PULSE;
            cur_icp  <= 1'b0;
            cur_ee   <= go_ee;
            cur_op   <= ssp_fop;
            cur_addr <= go_ee ? ee_addr : ssp_addr;
            fl_wdata <= data;
            st_done  <= 1'b0;
            st_err   <= 1'b0;
          end else if (go_start) begin
            st_done <= 1'b1;
            st_err  <= 1'b1;
            if (go_read) data <= READ_FILL;
          end
        end
        ST_PULSE: state <= ST_WAIT;
        ST_WAIT: begin
          if (~fl_busy) begin
            state <= ST_DONE;
          end
        end
        ST_DONE: begin
          state <= ST_IDLE;
          if (cur_icp) begin
            icp_done  <= 1'b1;
            icp_rdata <= cur_op == F_RD ? fl_rdata : RST8;
          end else begin
            st_done <= 1'b1;
            if (cur_op == F_RD) data <= fl_rdata;
          end
          if (cur_op == F_MASS) begin
            programmed <= '0;
          end else if (~cur_ee && cur_op == F_SERA) begin
            programmed[fps_sec(cur_addr)] <= 1'b0;
          end else if (~cur_ee && ~cur_icp && cur_op == F_PROG) begin
            programmed[fps_sec(cur_addr)] <= 1'b1;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  assign fl_start = state == ST_PULSE;
  assign fl_op    = state == ST_IDLE ? F_NONE : cur_op;
  assign fl_ee    = cur_ee;
  assign fl_addr  = cur_addr;

endmodule : fps_top

`default_nettype wire
